/* File: core/nvh_host.sv */
// Host controller driving the pins of an 8K x 8 nonvolatile static RAM
`timescale 1ns/1ns
`default_nettype none
module nvh_host
   import nvh_pkg::*;
#(
   parameter int STORE_CYC   = STORE_CYC_DEF,
   parameter int RESTORE_CYC = RESTORE_CYC_DEF
) (
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic              clk_en,
   input  wire logic              cmd_valid,
   input  wire logic [1:0]        cmd_kind,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_wdata,
   output logic                   cmd_ready,
   output logic                   rsp_done,
   output logic                   rsp_err,
   output logic [DATA_W-1:0]      rsp_rdata,
   input  wire logic              supply_ok,
   input  wire logic              supply_low,
   output logic                   chip_select_n,
   output logic                   output_gate_n,
   output logic                   write_strobe_n,
   output logic                   nonvolatile_select_n,
   output logic [ADDR_W-1:0]      address_pins,
   output logic [DATA_W-1:0]      data_pins_o,
   input  wire logic [DATA_W-1:0] data_pins_i,
   output logic                   data_pins_oe_n
);

   nvh_state_t        state_q, state_d;
   nvh_cmd_t          cmd_q, cmd_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic              err_q, err_d;
   logic              done_q, done_d;
   logic              ready_q, ready_d;
   logic [3:0]        pins_q, pins_d;
   logic              dq_oe_n_q, dq_oe_n_d;
   logic              tmr_load;
   logic [TMR_W-1:0]  tmr_val;
   logic              tmr_zero;

   // Pin inputs are asynchronous to core_clk
   logic [DATA_W-1:0] dq_m_q, dq_s_q;
   logic              ok_m_q, ok_s_q;
   logic              low_m_q, low_s_q;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dq_m_q  <= '0;
         dq_s_q  <= '0;
         ok_m_q  <= 1'b0;
         ok_s_q  <= 1'b0;
         low_m_q <= 1'b1;
         low_s_q <= 1'b1;
      end else if (clk_en) begin
         dq_m_q  <= data_pins_i;
         dq_s_q  <= dq_m_q;
         ok_m_q  <= supply_ok;
         ok_s_q  <= ok_m_q;
         low_m_q <= supply_low;
         low_s_q <= low_m_q;
      end
   end

   function automatic logic [3:0] pin_set(nvh_state_t st, nvh_cmd_t c);
      logic [3:0] p;
      p = PINS_OFF;
      if (st == ST_SETUP || st == ST_STROBE) begin
         p[PIN_CE] = 1'b0;
         unique case (c)
            CMD_READ: begin
               p[PIN_OE] = 1'b0;
            end
            CMD_WRITE: begin
               p[PIN_WE] = (st == ST_SETUP);
            end
            CMD_STORE: begin
               p[PIN_NE] = 1'b0;
               p[PIN_WE] = (st == ST_SETUP);
            end
            CMD_RECALL: begin
               p[PIN_OE] = 1'b0;
               p[PIN_NE] = (st == ST_SETUP);
            end
         endcase
      end else if (st == ST_HOLD && c == CMD_WRITE) begin
         // Strobe rises first so data and address outlast the write edge
         p[PIN_CE] = 1'b0;
      end
      return p;
   endfunction

   function automatic logic [TMR_W-1:0] dur(nvh_state_t st, nvh_cmd_t c);
      int n;
      n = 1;
      if (st == ST_PWRUP) begin
         n = RESTORE_CYC;
      end else if (st == ST_STROBE) begin
         unique case (c)
            CMD_READ:  n = ACCESS_CYC + SYNC_CYC;
            CMD_WRITE: n = WR_PULSE_CYC;
            default:   n = NV_INIT_CYC;
         endcase
      end else if (st == ST_WAIT) begin
         n = (c == CMD_STORE) ? STORE_CYC : RECALL_CYC;
      end
      return TMR_W'(n - 1);
   endfunction

   always_comb begin
      state_d = state_q;
      cmd_d   = cmd_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      err_d   = err_q;
      unique case (state_q)
         ST_PWRUP: begin
            if (ok_s_q && tmr_zero) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (cmd_valid) begin
               cmd_d   = nvh_cmd_t'(cmd_kind);
               addr_d  = cmd_addr;
               wdata_d = cmd_wdata;
               err_d   = 1'b0;
               if (nvh_cmd_t'(cmd_kind) == CMD_STORE && low_s_q) begin
                  err_d   = 1'b1;
                  state_d = ST_DONE;
               end else begin
                  state_d = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            state_d = ST_STROBE;
         end
         ST_STROBE: begin
            if (tmr_zero) begin
               if (cmd_q == CMD_READ) begin
                  rdata_d = dq_s_q;
               end
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // Store and recall pins released here (a write still holds chip select): the nv cycle now runs on its own inside the part
            state_d = (cmd_q[1]) ? ST_WAIT : ST_DONE;
         end
         ST_WAIT: begin
            if (tmr_zero) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_PWRUP;
         end
      endcase
      if (!ok_s_q) begin
         state_d = ST_PWRUP;
      end
      done_d    = (state_d == ST_DONE);
      ready_d   = (state_d == ST_IDLE);
      pins_d    = pin_set(state_d, cmd_d);
      dq_oe_n_d = !(cmd_d == CMD_WRITE &&
                    (state_d == ST_SETUP || state_d == ST_STROBE || state_d == ST_HOLD));
      tmr_load  = (state_d != state_q) || (state_q == ST_PWRUP && !ok_s_q);
      tmr_val   = dur(state_d, cmd_d);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q   <= ST_PWRUP;
         cmd_q     <= CMD_READ;
         addr_q    <= '0;
         wdata_q   <= '0;
         rdata_q   <= '0;
         err_q     <= 1'b0;
         done_q    <= 1'b0;
         ready_q   <= 1'b0;
         pins_q    <= PINS_OFF;
         dq_oe_n_q <= 1'b1;
      end else if (clk_en) begin
         state_q   <= state_d;
         cmd_q     <= cmd_d;
         addr_q    <= addr_d;
         wdata_q   <= wdata_d;
         rdata_q   <= rdata_d;
         err_q     <= err_d;
         done_q    <= done_d;
         ready_q   <= ready_d;
         pins_q    <= pins_d;
         dq_oe_n_q <= dq_oe_n_d;
      end
   end

   nvh_timer u_timer (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .load     (tmr_load),
      .load_val (tmr_val),
      .expired  (tmr_zero)
   );

   assign cmd_ready            = ready_q;
   assign rsp_done             = done_q;
   assign rsp_err              = err_q;
   assign rsp_rdata            = rdata_q;
   assign chip_select_n        = pins_q[PIN_CE];
   assign output_gate_n        = pins_q[PIN_OE];
   assign write_strobe_n       = pins_q[PIN_WE];
   assign nonvolatile_select_n = pins_q[PIN_NE];
   assign address_pins         = addr_q;
   assign data_pins_o          = wdata_q;
   assign data_pins_oe_n       = dq_oe_n_q;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_store_trig;
      $fell(write_strobe_n) && !nonvolatile_select_n;
   endsequence
   sequence s_store_release;
      ##[1:4] (write_strobe_n && nonvolatile_select_n && chip_select_n);
   endsequence

   a_write_gate_high: assert property (
      (!write_strobe_n && nonvolatile_select_n) |-> output_gate_n)
      else $error("output gate low during write");
   a_write_addr_stable: assert property (
      (!chip_select_n && $past(!chip_select_n)) |-> $stable(address_pins))
      else $error("address moved while selected");
   a_store_strobe_last: assert property (
      s_store_trig |-> $past(!chip_select_n && output_gate_n && !nonvolatile_select_n))
      else $error("store not begun by strobe falling last");
   a_store_self_run: assert property (
      s_store_trig |-> s_store_release)
      else $error("store initiation not released");
   a_recall_nv_last: assert property (
      ($fell(nonvolatile_select_n) && write_strobe_n && !output_gate_n)
      |-> $past(!chip_select_n && !output_gate_n && write_strobe_n))
      else $error("recall not begun by nv select falling last");
   a_pwrup_quiet: assert property (
      (state_q == ST_PWRUP) |-> (chip_select_n && write_strobe_n && data_pins_oe_n))
      else $error("bus active during power-up");
   a_restore_elapsed: assert property (
      ($past(state_q) == ST_PWRUP && state_q == ST_IDLE) |-> $past(tmr_zero && ok_s_q))
      else $error("access allowed before restore time");
   a_no_contention: assert property (
      !data_pins_oe_n |-> (output_gate_n && nonvolatile_select_n))
      else $error("host drives data while part may drive");
   a_store_inhibit: assert property (
      (state_q == ST_IDLE && cmd_valid && cmd_kind == CMD_STORE && low_s_q)
      |=> (state_q == ST_DONE && err_q))
      else $error("store issued under low supply");
   a_done_pulse: assert property (
      rsp_done |=> !rsp_done)
      else $error("done longer than one cycle");

endmodule
`default_nettype wire

/* File: core/nvh_pkg.sv */
// Constants and types for the nonvolatile SRAM host controller
`default_nettype none
package nvh_pkg;

   localparam int CLK_PERIOD_NS   = 20;
   localparam int ADDR_W          = 13;
   localparam int DATA_W          = 8;
   localparam int TMR_W           = 20;
   localparam int SYNC_CYC        = 2;

   localparam int STORE_TIME_MS   = 10;
   localparam int STORE_CYC_DEF   = STORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RECALL_TIME_US  = 20;
   localparam int RECALL_CYC      = (RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTORE_TIME_US = 550;
   localparam int RESTORE_CYC_DEF = (RESTORE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_TIME_NS  = 55;
   localparam int ACCESS_CYC      = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_PULSE_NS     = 45;
   localparam int WR_PULSE_CYC    = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NV_INIT_NS      = 20;
   localparam int NV_INIT_CYC     = (NV_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Control pin vector order {chip select, output gate, write strobe, nv select}
   localparam int          PIN_CE   = 3;
   localparam int          PIN_OE   = 2;
   localparam int          PIN_WE   = 1;
   localparam int          PIN_NE   = 0;
   localparam logic [3:0]  PINS_OFF = 4'hf;

   typedef enum logic [1:0] {
      CMD_READ   = 2'h0,
      CMD_WRITE  = 2'h1,
      CMD_STORE  = 2'h2,
      CMD_RECALL = 2'h3
   } nvh_cmd_t;

   typedef enum logic [2:0] {
      ST_PWRUP  = 3'h0,
      ST_IDLE   = 3'h1,
      ST_SETUP  = 3'h3,
      ST_STROBE = 3'h2,
      ST_HOLD   = 3'h6,
      ST_WAIT   = 3'h7,
      ST_DONE   = 3'h5
   } nvh_state_t;

endpackage
`default_nettype wire

/* File: core/nvh_timer.sv */
// Down counter that times pin phases and nonvolatile cycles
`timescale 1ns/1ns
`default_nettype none
module nvh_timer
   import nvh_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   input  wire logic             load,
   input  wire logic [TMR_W-1:0] load_val,
   output logic                  expired
);

   logic [TMR_W-1:0] cnt_q;
   logic [TMR_W-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = load_val;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
      end else if (clk_en) begin
         cnt_q <= cnt_d;
      end
   end

   assign expired = (cnt_q == '0);

endmodule
`default_nettype wire

/* File: sim/nvh_sram_model.sv */
// Behavioural model of the nonvolatile SRAM on the far side of the host pins
`timescale 1ns/1ns
`default_nettype none
module nvh_sram_model (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        ne_n,
   input  wire logic [12:0] addr,
   input  wire logic [7:0]  dq_i,
   input  wire logic        supply_ok,
   input  wire logic        supply_low,
   output logic [7:0]       dq_o,
   output logic             dq_drv
);
   logic [7:0] mem [0:8191];
   logic [7:0] nv  [0:8191];
   logic [7:0] last_q;
   logic       busy_q;
   wire logic  rd_st     = !ce_n && !oe_n && we_n && ne_n;
   wire logic  store_st  = !ce_n && !ne_n && !we_n && oe_n;
   wire logic  recall_st = !ce_n && !oe_n && !ne_n && we_n;
   initial begin
      busy_q = 1'b0;
      last_q = 8'h00;
      foreach (nv[i]) nv[i] = 8'h00;
   end
   // Edge triggered, so a held state never starts a second cycle
   always @(posedge store_st) if (!busy_q && !supply_low) begin
      busy_q = 1'b1;
      foreach (nv[i]) nv[i] = mem[i];
      #200 busy_q = 1'b0;
   end
   always @(posedge recall_st or posedge supply_ok) if (!busy_q) begin
      busy_q = 1'b1;
      foreach (mem[i]) mem[i] = 8'h00;
      foreach (mem[i]) mem[i] = nv[i];
      #200 busy_q = 1'b0;
   end
   always @(posedge we_n or posedge ce_n)
      if (!busy_q && ne_n && !(we_n && ce_n)) mem[addr] = dq_i;
   always @* if (dq_drv) last_q = mem[addr];
   // Released lines show the inverse of the last byte, never a lucky match
   assign dq_drv = rd_st && !busy_q;
   assign dq_o   = dq_drv ? mem[addr] : ~last_q;
endmodule
`default_nettype wire

/* File: sim/test_nvh_host.sv */
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_nvh_host;
   import nvh_pkg::*;
   localparam int ST_CYC = 20;
   localparam int RS_CYC = 10;
   logic              core_clk, arst_n, clk_en, cmd_valid, supply_ok, supply_low;
   logic [1:0]        cmd_kind;
   logic [ADDR_W-1:0] cmd_addr;
   logic [DATA_W-1:0] cmd_wdata, rsp_rdata, dq_o, data_pins_o, data_pins_i;
   logic              cmd_ready, rsp_done, rsp_err, dq_drv, data_pins_oe_n;
   logic              chip_select_n, output_gate_n, write_strobe_n, nonvolatile_select_n;
   logic [ADDR_W-1:0] address_pins;
   int                failures, n_checks;
   // Contention shows as unknown so it can never read back as good data
   assign data_pins_i = !data_pins_oe_n ? (dq_drv ? 8'hxx : data_pins_o) : dq_o;
   nvh_host #(.STORE_CYC(ST_CYC), .RESTORE_CYC(RS_CYC)) DUT (.core_clk(core_clk),
      .arst_n(arst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_done(rsp_done),
      .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .supply_ok(supply_ok), .supply_low(supply_low),
      .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
      .write_strobe_n(write_strobe_n), .nonvolatile_select_n(nonvolatile_select_n),
      .address_pins(address_pins), .data_pins_o(data_pins_o), .data_pins_i(data_pins_i),
      .data_pins_oe_n(data_pins_oe_n));
   nvh_sram_model mem_dev (.ce_n(chip_select_n), .oe_n(output_gate_n), .we_n(write_strobe_n),
      .ne_n(nonvolatile_select_n), .addr(address_pins), .dq_i(data_pins_i),
      .supply_ok(supply_ok), .supply_low(supply_low), .dq_o(dq_o), .dq_drv(dq_drv));
   always #10 core_clk = ~core_clk;
   always @(negedge core_clk) if (data_pins_oe_n === 1'b0)
      `CHK({output_gate_n, nonvolatile_select_n}, 2'b11)
   task automatic issue(input logic [1:0] k, input logic [12:0] a, input logic [7:0] d,
                        output int lat);
      int i;
      i = 0;
      while (cmd_ready !== 1'b1 && i < 5000) begin
         @(posedge core_clk);
         #1 i++;
      end
      if (i >= 5000) failures++;
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_kind  <= k;
      cmd_addr  <= a;
      cmd_wdata <= d;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      lat = 0;
      // A refused command answers at the take edge itself
      #1;
      while (rsp_done !== 1'b1 && lat < 3000) begin
         @(posedge core_clk);
         #1 lat++;
      end
      if (lat >= 3000) failures++;
   endtask
   task automatic t_rw;
      int         lat;
      logic [12:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aa5, 13'h1000};
      logic [7:0]  d [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
      foreach (a[i]) begin
         issue(CMD_WRITE, a[i], d[i], lat);
         `CHK(lat, 1 + WR_PULSE_CYC + 1)
      end
      foreach (a[i]) begin
         issue(CMD_READ, a[i], 8'h00, lat);
         `CHK(lat, 1 + ACCESS_CYC + SYNC_CYC + 1)
         `CHK(rsp_rdata, d[i])
      end
   endtask
   task automatic t_freeze;
      int lat;
      while (cmd_ready !== 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      // Enable low mid-strobe stretches the pulse, never cuts it
      fork
         issue(CMD_WRITE, 13'h0042, 8'h96, lat);
         begin
            repeat (3) @(posedge core_clk);
            clk_en <= 1'b0;
            repeat (4) @(posedge core_clk);
            clk_en <= 1'b1;
         end
      join
      `CHK(lat, 1 + WR_PULSE_CYC + 1 + 4)
      issue(CMD_READ, 13'h0042, 8'h00, lat);
      `CHK(rsp_rdata, 8'h96)
   endtask
   task automatic t_store_recall;
      int lat;
      issue(CMD_WRITE, 13'h0123, 8'h5a, lat);
      issue(CMD_STORE, 13'h0000, 8'h00, lat);
      `CHK(rsp_err, 1'b0)
      `CHK(lat >= ST_CYC && lat <= ST_CYC + 6, 1'b1)
      issue(CMD_WRITE, 13'h0123, 8'ha5, lat);
      issue(CMD_READ, 13'h0123, 8'h00, lat);
      `CHK(rsp_rdata, 8'ha5)
      repeat (2) begin
         issue(CMD_RECALL, 13'h0000, 8'h00, lat);
         `CHK(lat >= RECALL_CYC && lat <= RECALL_CYC + 6, 1'b1)
         issue(CMD_READ, 13'h0123, 8'h00, lat);
         `CHK(rsp_rdata, 8'h5a)
      end
   endtask
   task automatic t_inhibit;
      int lat;
      @(posedge core_clk);
      supply_low <= 1'b1;
      issue(CMD_WRITE, 13'h0123, 8'hc3, lat);
      issue(CMD_STORE, 13'h0000, 8'h00, lat);
      `CHK(rsp_err, 1'b1)
      `CHK(lat, 0)
      @(posedge core_clk);
      supply_low <= 1'b0;
      issue(CMD_RECALL, 13'h0000, 8'h00, lat);
      issue(CMD_READ, 13'h0123, 8'h00, lat);
      `CHK(rsp_rdata, 8'h5a)
   endtask
   task automatic t_powerup;
      int lat;
      int i;
      issue(CMD_WRITE, 13'h0123, 8'h77, lat);
      @(posedge core_clk);
      supply_ok <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1 `CHK({chip_select_n, write_strobe_n, cmd_ready}, 3'b110)
      @(posedge core_clk);
      supply_ok <= 1'b1;
      i = 0;
      while (cmd_ready !== 1'b1 && i < 100) begin
         @(posedge core_clk);
         #1 i++;
      end
      `CHK(i > RS_CYC && i <= RS_CYC + 6, 1'b1)
      issue(CMD_READ, 13'h0123, 8'h00, lat);
      `CHK(rsp_rdata, 8'h5a)
   endtask
   task automatic wrap_up;
      if (failures == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #500000 failures++;
      wrap_up();
   end
   initial begin
      {core_clk, arst_n, cmd_valid, supply_ok, supply_low} = 5'h00;
      clk_en    = 1'b1;
      cmd_kind  = 2'h0;
      cmd_addr  = 13'h0000;
      cmd_wdata = 8'h00;
      failures  = 0;
      n_checks  = 0;
      repeat (6) @(posedge core_clk);
      arst_n    <= 1'b1;
      supply_ok <= 1'b1;
      t_rw();
      t_freeze();
      t_store_recall();
      t_inhibit();
      t_powerup();
      wrap_up();
   end
endmodule
`default_nettype wire
